/* sim/edpc_asserts.sv */
`timescale 1ns/1ps
module edpc_asserts (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic powerUpStart,
   input wire logic powerDownStart,
   input wire logic rxPowered,
   input wire logic detectPulse
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   a_up_sets_pwr: assert property (powerUpStart |-> rxPowered)
      else $error("power up did not set power state");
   a_down_clears_pwr: assert property (powerDownStart |-> !rxPowered)
      else $error("power down did not clear power state");
   a_up_from_off: assert property (powerUpStart |-> !$past(rxPowered))
      else $error("power up started while already up");
   a_down_from_on: assert property (powerDownStart |-> $past(rxPowered))
      else $error("power down started while already down");
   a_rise_has_cause: assert property ($rose(rxPowered) |-> powerUpStart || $past(powerUpStart))
      else $error("power state rose without a start");
   a_fall_has_cause: assert property ($fell(rxPowered) |-> powerDownStart || $past(powerDownStart))
      else $error("power state fell without a start");
   a_burst_first: assert property (powerUpStart |=> detectPulse)
      else $error("no detect pulse after power up");
   a_pulse_gap: assert property (detectPulse |=> !detectPulse [*7])
      else $error("detect pulses too close");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped before taken");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped before taken");
endmodule : edpc_asserts

bind edpc_top edpc_asserts u_edpc_asserts (.clk_sys(clk_sys), .nrst(nrst),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .powerUpStart(powerUpStart), .powerDownStart(powerDownStart), .rxPowered(rxPowered),
   .detectPulse(detectPulse));

/* sim/edpc_line_model.sv */
`timescale 1ns/1ps
module edpc_line_model (
   input wire logic clk_sys,
   output logic lineDataEvent,
   output logic lineErrorEvent,
   output logic lineEnergyPresent
);
   initial begin
      lineDataEvent = 1'b0;
      lineErrorEvent = 1'b0;
      lineEnergyPresent = 1'b0;
   end
   // events are single-cycle pulses with a quiet cycle between them
   task automatic send(input logic err, input int n);
      repeat (n) begin
         @(posedge clk_sys);
         if (err) lineErrorEvent <= 1'b1;
         else lineDataEvent <= 1'b1;
         @(posedge clk_sys);
         lineErrorEvent <= 1'b0;
         lineDataEvent <= 1'b0;
      end
   endtask : send
   task automatic energy(input logic v);
      @(posedge clk_sys);
      lineEnergyPresent <= v;
   endtask : energy
endmodule : edpc_line_model

/* sim/edpc_top_tb.sv */
`timescale 1ns/1ps
`include "edpc_defs.svh"
module edpc_top_tb;
   localparam logic [7:0] A_CTRL = `EDPC_CTRL_IDX << `EDPC_IDX_LSB;
   localparam logic [7:0] A_STAT = `EDPC_STAT_IDX << `EDPC_IDX_LSB;
   localparam logic [7:0] A_MASK = `EDPC_MASK_IDX << `EDPC_IDX_LSB;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [3:0] wstrb = 4'hf, strb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid, dEv, eEv, enP, upS, dnS, rxP, dPulse, irq;
   logic [1:0] bresp, rresp, rs;
   int miscompares = 0, n_tests = 0, nUp = 0, nDn = 0, nPulse = 0;
   always #20 clk_sys = ~clk_sys;
   edpc_top #(.QUIET_CYCLES(64)) u_edpc_top (.clk_sys(clk_sys), .nrst(nrst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .lineDataEvent(dEv), .lineErrorEvent(eEv), .lineEnergyPresent(enP),
      .powerUpStart(upS), .powerDownStart(dnS), .rxPowered(rxP), .detectPulse(dPulse),
      .irq(irq));
   edpc_line_model u_edpc_line_model (.clk_sys(clk_sys), .lineDataEvent(dEv),
      .lineErrorEvent(eEv), .lineEnergyPresent(enP));
   always @(posedge clk_sys) begin
      if (upS === 1'b1) nUp++;
      if (dnS === 1'b1) nDn++;
      if (dPulse === 1'b1) nPulse++;
   end
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk32
   task automatic chk1(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask : chk1
   // bready and rready go up with the request and drop on the answering edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, done;
      aw = 1'b1;
      w = 1'b1;
      done = 1'b0;
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      wstrb <= strb;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge clk_sys);
         if (aw && awready) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
         if (bvalid) begin
            rs = bresp;
            done = 1'b1;
         end
      end
      bready <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic done;
      done = 1'b0;
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge clk_sys);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            rd = rdata;
            rs = rresp;
            done = 1'b1;
         end
      end
      rready <= 1'b0;
      chk32(rd, exp);
   endtask : rdc
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim
   initial begin
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      rdc(A_CTRL, 32'h6011);
      rdc(A_STAT, 32'h0);
      rdc(8'h00, 32'h0);
      chk32({30'h0, rs}, 32'h2);
      wr(8'h00, 32'h1);
      chk32({30'h0, rs}, 32'h2);
      $display("test reset_map done");
      wr(A_MASK, 32'hf);
      u_edpc_line_model.energy(1'b1);
      wr(A_CTRL, 32'he011);
      u_edpc_line_model.send(1'b0, 1);
      cyc(40);
      chk32(nUp, 1);
      chk32(nPulse, 4);
      rdc(A_CTRL, 32'he511);
      rdc(A_CTRL, 32'he411);
      rdc(A_STAT, 32'h5);
      chk1(irq, 1'b1);
      wr(A_STAT, 32'hf);
      cyc(2);
      chk1(irq, 1'b0);
      u_edpc_line_model.energy(1'b0);
      cyc(5);
      chk32(nDn, 1);
      rdc(A_CTRL, 32'he011);
      $display("test auto_up_down done");
      u_edpc_line_model.energy(1'b1);
      wr(A_CTRL, 32'he812);
      u_edpc_line_model.send(1'b0, 1);
      cyc(80);
      u_edpc_line_model.send(1'b0, 1);
      cyc(5);
      chk1(rxP, 1'b0);
      u_edpc_line_model.send(1'b0, 1);
      cyc(40);
      chk32(nUp, 2);
      chk32(nPulse, 5);
      rdc(A_CTRL, 32'hed12);
      $display("test quiet_single done");
      wr(A_STAT, 32'hf);
      wr(A_CTRL, 32'hf812);
      cyc(5);
      chk32(nDn, 2);
      rdc(A_CTRL, 32'he812);
      wr(A_CTRL, 32'hf812);
      cyc(40);
      chk32(nUp, 3);
      chk32(nPulse, 6);
      rdc(A_CTRL, 32'hec12);
      $display("test manual done");
      wr(A_CTRL, 32'he02f);
      u_edpc_line_model.send(1'b0, 1);
      u_edpc_line_model.send(1'b1, 1);
      cyc(3);
      rdc(A_CTRL, 32'he42f);
      u_edpc_line_model.send(1'b1, 1);
      cyc(3);
      rdc(A_CTRL, 32'he62f);
      rdc(A_CTRL, 32'he42f);
      chk32(nDn, 2);
      $display("test error_threshold done");
      wr(A_CTRL, 32'h602f);
      u_edpc_line_model.energy(1'b0);
      cyc(10);
      chk1(rxP, 1'b1);
      wr(A_CTRL, 32'h702f);
      cyc(5);
      chk32(nDn, 2);
      strb = 4'h1;
      wr(A_CTRL, 32'hffff_e0a1);
      strb = 4'hf;
      rdc(A_CTRL, 32'h64a1);
      $display("test disabled done");
      end_sim();
   end
   initial begin
      repeat (5000) @(posedge clk_sys);
      miscompares++;
      end_sim();
   end
endmodule : edpc_top_tb

/* src/edpc_defs.svh */
`ifndef EDPC_DEFS_SVH
`define EDPC_DEFS_SVH
`define EDPC_CTRL_IDX 6'h1d
`define EDPC_STAT_IDX 6'h1e
`define EDPC_MASK_IDX 6'h1f
`define EDPC_IDX_LSB 2
`define EDPC_B_ENABLE 15
`define EDPC_B_AUTOUP 14
`define EDPC_B_AUTODN 13
`define EDPC_B_MANUAL 12
`define EDPC_B_BURSTDIS 11
`define EDPC_B_PWR 10
`define EDPC_B_ERRMET 9
`define EDPC_B_DATAMET 8
`define EDPC_THR_RST 4'h1
`define EDPC_QUIET_MS 2000
`define EDPC_CLK_KHZ 25000
`define EDPC_BURST_LEN 3'h4
`define EDPC_SINGLE_LEN 3'h1
`define EDPC_PULSE_GAP 4'h7
`define EDPC_RESP_OKAY 2'h0
`define EDPC_RESP_SLVERR 2'h2
`endif

/* src/edpc_pkg.sv */
package edpc_pkg;
   typedef struct packed {
      logic enable;
      logic autoUp;
      logic autoDown;
      logic burstDis;
      logic [3:0] errThr;
      logic [3:0] dataThr;
   } edpc_ctrl_type;
   typedef struct packed {
      logic powerDown;
      logic powerUp;
      logic errMet;
      logic dataMet;
   } edpc_irq_type;
   typedef enum logic [1:0] {
      EDPC_OFF = 2'b01,
      EDPC_ON = 2'b10
   } edpc_pwr_type;
endpackage : edpc_pkg

/* src/edpc_top.sv */
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`include "edpc_defs.svh"
module edpc_top
   import edpc_pkg::*;
#(
   parameter int unsigned QUIET_CYCLES = `EDPC_QUIET_MS * `EDPC_CLK_KHZ
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic lineDataEvent,
   input wire logic lineErrorEvent,
   input wire logic lineEnergyPresent,
   output logic powerUpStart,
   output logic powerDownStart,
   output logic rxPowered,
   output logic detectPulse,
   output logic irq
);
   // ---------------- write channel
   logic awReady_reg;
   logic wReady_reg;
   logic bValid_reg;
   logic [1:0] bResp_reg;
   logic awHave_reg;
   logic wHave_reg;
   logic [7:0] awAddr_reg;
   logic [31:0] wData_reg;
   logic [3:0] wStrb_reg;
   wire awFire = s_axi_awvalid && awReady_reg;
   wire wFire = s_axi_wvalid && wReady_reg;
   wire awAvail = awHave_reg || awFire;
   wire wAvail = wHave_reg || wFire;
   wire wrDo = awAvail && wAvail && !bValid_reg;
   wire awHaveNext = awAvail && !wrDo;
   wire wHaveNext = wAvail && !wrDo;
   wire [7:0] wrAddr = awFire ? s_axi_awaddr : awAddr_reg;
   wire [31:0] wrData = wFire ? s_axi_wdata : wData_reg;
   wire [3:0] wrStrb = wFire ? s_axi_wstrb : wStrb_reg;
   wire [5:0] wrIdx = wrAddr[7:`EDPC_IDX_LSB];
   wire wrCtrl = wrDo && (wrIdx == `EDPC_CTRL_IDX);
   wire wrStat = wrDo && (wrIdx == `EDPC_STAT_IDX);
   wire wrMask = wrDo && (wrIdx == `EDPC_MASK_IDX);
   wire wrMapped = wrCtrl || wrStat || wrMask;
   wire wrLo = wrStrb[0];
   wire wrHi = wrStrb[1];

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         awReady_reg <= 1'b0;
         wReady_reg <= 1'b0;
         awHave_reg <= 1'b0;
         wHave_reg <= 1'b0;
      end else begin
         awReady_reg <= !awHaveNext;
         wReady_reg <= !wHaveNext;
         awHave_reg <= awHaveNext;
         wHave_reg <= wHaveNext;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         awAddr_reg <= 8'h00;
         wData_reg <= 32'h0000_0000;
         wStrb_reg <= 4'h0;
      end else begin
         if (awFire) begin
            awAddr_reg <= s_axi_awaddr;
         end
         if (wFire) begin
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         bValid_reg <= 1'b0;
         bResp_reg <= `EDPC_RESP_OKAY;
      end else if (wrDo) begin
         bValid_reg <= 1'b1;
         bResp_reg <= wrMapped ? `EDPC_RESP_OKAY : `EDPC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bValid_reg <= 1'b0;
      end
   end

   // ---------------- control register
   edpc_ctrl_type ctrl_reg;
   edpc_ctrl_type ctrl_next;
   logic manualPend_reg;
   logic manualSet;
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wrCtrl && wrHi) begin
         ctrl_next.enable = wrData[`EDPC_B_ENABLE];
         ctrl_next.autoUp = wrData[`EDPC_B_AUTOUP];
         ctrl_next.autoDown = wrData[`EDPC_B_AUTODN];
         ctrl_next.burstDis = wrData[`EDPC_B_BURSTDIS];
      end
      if (wrCtrl && wrLo) begin
         ctrl_next.errThr = wrData[7:4];
         ctrl_next.dataThr = wrData[3:0];
      end
   end
   assign manualSet = wrCtrl && wrHi && wrData[`EDPC_B_MANUAL];

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         ctrl_reg.enable <= 1'b0;
         ctrl_reg.autoUp <= 1'b1;
         ctrl_reg.autoDown <= 1'b1;
         ctrl_reg.burstDis <= 1'b0;
         ctrl_reg.errThr <= `EDPC_THR_RST;
         ctrl_reg.dataThr <= `EDPC_THR_RST;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // ---------------- event counters and quiet timer
   logic [3:0] dataCnt_reg;
   logic [3:0] errCnt_reg;
   logic [25:0] quiet_reg;
   logic pwrChange;
   wire quietDone = (quiet_reg == 26'(QUIET_CYCLES - 1));
   wire cntClear = !ctrl_reg.enable || quietDone || pwrChange;
   wire dataReach = ctrl_reg.enable && (dataCnt_reg >= ctrl_reg.dataThr);
   wire errReach = ctrl_reg.enable && (errCnt_reg >= ctrl_reg.errThr);

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         quiet_reg <= 26'h0;
      end else if (lineDataEvent || !ctrl_reg.enable || quietDone) begin
         quiet_reg <= 26'h0;
      end else begin
         quiet_reg <= quiet_reg + 26'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         dataCnt_reg <= 4'h0;
         errCnt_reg <= 4'h0;
      end else if (cntClear) begin
         dataCnt_reg <= 4'h0;
         errCnt_reg <= 4'h0;
      end else begin
         if (lineDataEvent && dataCnt_reg != 4'hf) begin
            dataCnt_reg <= dataCnt_reg + 4'h1;
         end
         if (lineErrorEvent && errCnt_reg != 4'hf) begin
            errCnt_reg <= errCnt_reg + 4'h1;
         end
      end
   end

   logic dataReachD_reg;
   logic errReachD_reg;
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         dataReachD_reg <= 1'b0;
         errReachD_reg <= 1'b0;
      end else begin
         dataReachD_reg <= dataReach;
         errReachD_reg <= errReach;
      end
   end
   wire dataMetEv = dataReach && !dataReachD_reg;
   wire errMetEv = errReach && !errReachD_reg;

   // ---------------- power state machine
   edpc_pwr_type pwr_reg;
   edpc_pwr_type pwr_next;
   logic goUp;
   logic goDown;
   always_comb begin
      pwr_next = pwr_reg;
      goUp = 1'b0;
      goDown = 1'b0;
      unique case (pwr_reg)
         EDPC_OFF: begin
            if (ctrl_reg.enable && (manualPend_reg || (ctrl_reg.autoUp && dataReach))) begin
               pwr_next = EDPC_ON;
               goUp = 1'b1;
            end
         end
         EDPC_ON: begin
            if (ctrl_reg.enable &&
                (manualPend_reg || (ctrl_reg.autoDown && !lineEnergyPresent))) begin
               pwr_next = EDPC_OFF;
               goDown = 1'b1;
            end
         end
         default: begin
            pwr_next = EDPC_OFF;
         end
      endcase
   end
   assign pwrChange = goUp || goDown;

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         pwr_reg <= EDPC_OFF;
         powerUpStart <= 1'b0;
         powerDownStart <= 1'b0;
         rxPowered <= 1'b0;
      end else begin
         pwr_reg <= pwr_next;
         powerUpStart <= goUp;
         powerDownStart <= goDown;
         rxPowered <= (pwr_next == EDPC_ON);
      end
   end

   // manual request is held until the state machine takes it or enable is cleared
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         manualPend_reg <= 1'b0;
      end else if (manualSet) begin
         manualPend_reg <= 1'b1;
      end else if (pwrChange || !ctrl_reg.enable) begin
         manualPend_reg <= 1'b0;
      end
   end

   // ---------------- detect pulse burst
   logic [2:0] burstLeft_reg;
   logic [3:0] gap_reg;
   logic pulse_reg;
   wire pulseNow = (burstLeft_reg != 3'h0) && (gap_reg == 4'h0);
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         burstLeft_reg <= 3'h0;
         gap_reg <= 4'h0;
         pulse_reg <= 1'b0;
      end else begin
         pulse_reg <= pulseNow;
         if (goUp) begin
            burstLeft_reg <= ctrl_reg.burstDis ? `EDPC_SINGLE_LEN : `EDPC_BURST_LEN;
            gap_reg <= 4'h0;
         end else if (pulseNow) begin
            burstLeft_reg <= burstLeft_reg - 3'h1;
            gap_reg <= `EDPC_PULSE_GAP;
         end else if (gap_reg != 4'h0) begin
            gap_reg <= gap_reg - 4'h1;
         end
      end
   end
   assign detectPulse = pulse_reg;

   // ---------------- read channel
   logic arReady_reg;
   logic rValid_reg;
   logic [31:0] rData_reg;
   logic [1:0] rResp_reg;
   logic errMet_reg;
   logic dataMet_reg;
   edpc_irq_type stat_reg;
   edpc_irq_type mask_reg;
   wire arFire = s_axi_arvalid && arReady_reg;
   wire [5:0] rdIdx = s_axi_araddr[7:`EDPC_IDX_LSB];
   wire rdCtrl = arFire && (rdIdx == `EDPC_CTRL_IDX);
   wire rdStat = rdIdx == `EDPC_STAT_IDX;
   wire rdMask = rdIdx == `EDPC_MASK_IDX;
   wire rvNext = arFire || (rValid_reg && !s_axi_rready);
   wire [15:0] ctrlView = {ctrl_reg.enable, ctrl_reg.autoUp, ctrl_reg.autoDown,
      manualPend_reg, ctrl_reg.burstDis, pwr_reg == EDPC_ON, errMet_reg, dataMet_reg,
      ctrl_reg.errThr, ctrl_reg.dataThr};
   wire [31:0] rdMux = rdCtrl ? {16'h0000, ctrlView} :
      rdStat ? {28'h0, stat_reg} : rdMask ? {28'h0, mask_reg} : 32'h0;
   wire rdMapped = (rdIdx == `EDPC_CTRL_IDX) || rdStat || rdMask;

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         arReady_reg <= 1'b0;
         rValid_reg <= 1'b0;
         rData_reg <= 32'h0000_0000;
         rResp_reg <= `EDPC_RESP_OKAY;
      end else begin
         arReady_reg <= !rvNext;
         rValid_reg <= rvNext;
         if (arFire) begin
            rData_reg <= rdMux;
            rResp_reg <= rdMapped ? `EDPC_RESP_OKAY : `EDPC_RESP_SLVERR;
         end
      end
   end

   // threshold flags: a new event wins over the clearing read
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         errMet_reg <= 1'b0;
         dataMet_reg <= 1'b0;
      end else begin
         errMet_reg <= errMetEv || (errMet_reg && !rdCtrl);
         dataMet_reg <= dataMetEv || (dataMet_reg && !rdCtrl);
      end
   end

   // ---------------- interrupts
   edpc_irq_type statSet;
   edpc_irq_type statClr;
   assign statSet = '{powerDown: goDown, powerUp: goUp, errMet: errMetEv, dataMet: dataMetEv};
   assign statClr = (wrStat && wrLo) ? edpc_irq_type'(wrData[3:0]) : edpc_irq_type'(4'h0);

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         stat_reg <= 4'h0;
         mask_reg <= 4'h0;
         irq <= 1'b0;
      end else begin
         stat_reg <= statSet | (stat_reg & ~statClr);
         if (wrMask && wrLo) begin
            mask_reg <= wrData[3:0];
         end
         irq <= |((statSet | (stat_reg & ~statClr)) & mask_reg);
      end
   end

   assign s_axi_awready = awReady_reg;
   assign s_axi_wready = wReady_reg;
   assign s_axi_bvalid = bValid_reg;
   assign s_axi_bresp = bResp_reg;
   assign s_axi_arready = arReady_reg;
   assign s_axi_rvalid = rValid_reg;
   assign s_axi_rdata = rData_reg;
   assign s_axi_rresp = rResp_reg;
endmodule : edpc_top
